// [logic/msid_map.vh]
`ifndef MSID_MAP_VH
`define MSID_MAP_VH

// Request types on msg_type
`define MSID_TYPE_INTEGER 2'h0
`define MSID_TYPE_REFINE 2'h1

// First request-specific phase of a message
`define MSID_PHASE_BASE 4'h3

// Decoded item kinds on out_kind
`define MSID_KIND_STEPS 3'h0
`define MSID_KIND_REF8 3'h1
`define MSID_KIND_REF16 3'h2
`define MSID_KIND_DIST8 3'h3
`define MSID_KIND_DISTP 3'h4
`define MSID_KIND_SHAPE_MV 3'h5
`define MSID_KIND_REFINE_MV 3'h6

// Search path layout
`define MSID_STEP_V_MSB 7
`define MSID_STEP_V_LSB 4
`define MSID_STEP_H_MSB 3
`define MSID_STEP_H_LSB 0
`define MSID_STEPS_PER_DW 3'h4
`define MSID_PATH2_FIRST 6'h20
`define MSID_PATH2_DWORDS 3'h6

// Shape record dword slots within the distortion phase
`define MSID_REC_DISTP_A 3'h0
`define MSID_REC_DISTP_B 3'h1
`define MSID_REC_DIST8_A 3'h2
`define MSID_REC_DIST8_B 3'h3
`define MSID_REC_REF16 3'h4
`define MSID_REC_MV16 3'h5
`define MSID_REC_REF8 3'h6

// Shape numbering: 0 16x16, 1-2 16x8, 3-4 8x16, 5-8 8x8
`define MSID_SHAPE_16X8_0 6'h01
`define MSID_SHAPE_8X16_0 6'h03
`define MSID_SHAPE_8X8_0 6'h05
`define MSID_SHAPE_8X8_2 6'h07

// Field positions
`define MSID_REF16_MSB 19
`define MSID_REF16_LSB 16
`define MSID_DIST8_BITS 14
`define MSID_DISTP_BITS 15
`define MSID_MV_Y_MSB 31
`define MSID_MV_Y_LSB 16
`define MSID_MV_X_MSB 15
`define MSID_MV_X_LSB 0

// Refinement vector range in quarter samples: -2048.00 .. 2047.75
`define MSID_MV_MIN 16'he000
`define MSID_MV_MAX 16'h1fff

// Input buffer
`define MSID_FIFO_DEPTH 32
`define MSID_FIFO_AW 5

`endif

// [logic/msid_decoder.v]
`timescale 1ns/1ps
`include "msid_map.vh"

module msid_fifo #(
  parameter W = 8,
  parameter D = 32,
  parameter AW = 5
) (
  input wire mclk, // Clock
  input wire reset_n, // Async reset, active low
  input wire in_valid, // Write request
  output wire in_ready, // Room available
  input wire [W-1:0] in_data, // Write data
  output wire out_valid, // Data available
  input wire out_ready, // Read request
  output wire [W-1:0] out_data // Head of queue
);
  reg [W-1:0] mem_r [0:D-1];
  reg [AW:0] wr_ptr_r;
  reg [AW:0] rd_ptr_r;
  reg [AW:0] wr_ptr_nxt;
  reg [AW:0] rd_ptr_nxt;
  reg room_r;
  wire push;
  wire pop;

  // Ready comes from a flop so the sender never sees a compare path
  assign in_ready = room_r;
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign out_data = mem_r[rd_ptr_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers after this edge
  always @* begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    if (push)
      wr_ptr_nxt = wr_ptr_r + 1'b1;
    if (pop)
      rd_ptr_nxt = rd_ptr_r + 1'b1;
  end

  // Pointers and room flag; extra pointer bit tells full from empty
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
      room_r <= 1'b1;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      room_r <= (wr_ptr_nxt[AW] == rd_ptr_nxt[AW]) ||
                (wr_ptr_nxt[AW-1:0] != rd_ptr_nxt[AW-1:0]);
    end
  end

  // Storage needs no reset; empty flag guards stale words
  always @(posedge mclk) begin
    if (push)
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
  end
endmodule // msid_fifo

module msid_decoder (
  input wire mclk, // 100 MHz clock
  input wire reset_n, // Async reset, active low
  input wire msg_valid, // Message dword offered
  output wire msg_ready, // Buffer can take a dword
  input wire [31:0] msg_data, // Message dword
  input wire msg_first, // Dword is phase 0 dword 0 of a message
  input wire [1:0] msg_type, // Request type, sampled with msg_first
  input wire dec_ready, // Consumer can take a decoded item
  output wire out_valid, // One-cycle pulse: decoded item
  output wire [1:0] out_req_type, // Request type of the item
  output wire [2:0] out_kind, // Item kind
  output wire [5:0] out_index, // Step, shape or sub-block number
  output wire out_dir, // 0 first direction, 1 second
  output wire [15:0] out_step_v, // Four vertical moves, lowest step low
  output wire [15:0] out_step_h, // Four horizontal moves, lowest step low
  output wire [31:0] out_ref_idx, // Packed reference indices
  output wire [15:0] out_dist_lo, // Distortion of shape out_index
  output wire [15:0] out_dist_hi, // Distortion of shape out_index+1
  output wire [15:0] out_mv_y, // Vertical vector component
  output wire [15:0] out_mv_x, // Horizontal vector component
  output wire out_mv_in_range // Refinement vector within supported range
);
  localparam FW = 35;

  wire [FW-1:0] buf_out;
  wire buf_valid;
  wire pop;
  wire [31:0] dw;
  wire first;
  wire [1:0] typ_in;

  reg [6:0] dw_cnt_r;
  reg [1:0] typ_r;
  reg [6:0] idx;
  reg [1:0] typ;
  reg [3:0] rel;
  reg [2:0] d;
  reg hit_nxt;
  reg [2:0] kind_nxt;
  reg [5:0] index_nxt;
  reg dir_nxt;
  reg [15:0] step_v_nxt;
  reg [15:0] step_h_nxt;
  reg [31:0] ref_nxt;
  reg [15:0] dist_lo_nxt;
  reg [15:0] dist_hi_nxt;
  reg range_nxt;
  reg out_valid_r;
  reg [1:0] out_req_type_r;
  reg [2:0] out_kind_r;
  reg [5:0] out_index_r;
  reg out_dir_r;
  reg [15:0] out_step_v_r;
  reg [15:0] out_step_h_r;
  reg [31:0] out_ref_idx_r;
  reg [15:0] out_dist_lo_r;
  reg [15:0] out_dist_hi_r;
  reg [15:0] out_mv_y_r;
  reg [15:0] out_mv_x_r;
  reg out_mv_in_range_r;

  // Buffer absorbs bursts; a stalled consumer backs up into msg_ready
  msid_fifo #(
    .W(FW),
    .D(`MSID_FIFO_DEPTH),
    .AW(`MSID_FIFO_AW)
  ) u_buf (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(msg_valid),
    .in_ready(msg_ready),
    .in_data({msg_first, msg_type, msg_data}),
    .out_valid(buf_valid),
    .out_ready(dec_ready),
    .out_data(buf_out)
  );

  assign pop = buf_valid && dec_ready;
  assign first = buf_out[34];
  assign typ_in = buf_out[33:32];
  assign dw = buf_out[31:0];

  // Each output is a plain copy of its flop, no logic after the register
  assign out_valid = out_valid_r;
  assign out_req_type = out_req_type_r;
  assign out_kind = out_kind_r;
  assign out_index = out_index_r;
  assign out_dir = out_dir_r;
  assign out_step_v = out_step_v_r;
  assign out_step_h = out_step_h_r;
  assign out_ref_idx = out_ref_idx_r;
  assign out_dist_lo = out_dist_lo_r;
  assign out_dist_hi = out_dist_hi_r;
  assign out_mv_y = out_mv_y_r;
  assign out_mv_x = out_mv_x_r;
  assign out_mv_in_range = out_mv_in_range_r;

  // Dword position within the current message
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dw_cnt_r <= 7'h00;
      typ_r <= `MSID_TYPE_INTEGER;
    end else if (pop) begin
      if (first) begin
        dw_cnt_r <= 7'h01;
        typ_r <= typ_in;
      end else if (dw_cnt_r != 7'h7f) begin
        dw_cnt_r <= dw_cnt_r + 7'h01;
      end
    end
  end

  // Field decode of the dword at the head of the buffer
  always @* begin
    idx = first ? 7'h00 : dw_cnt_r;
    typ = first ? typ_in : typ_r;
    rel = idx[6:3] - `MSID_PHASE_BASE;
    d = idx[2:0];
    hit_nxt = 1'b0;
    kind_nxt = `MSID_KIND_STEPS;
    index_nxt = 6'h00;
    dir_nxt = 1'b0;
    // Byte k of the dword is step 4d+k, or 32+4d+k in the second path
    step_v_nxt = {dw[31:28], dw[23:20], dw[15:12], dw[`MSID_STEP_V_MSB:`MSID_STEP_V_LSB]};
    step_h_nxt = {dw[27:24], dw[19:16], dw[11:8], dw[`MSID_STEP_H_MSB:`MSID_STEP_H_LSB]};
    ref_nxt = dw;
    dist_lo_nxt = dw[15:0];
    dist_hi_nxt = dw[31:16];
    // Both components within -8192..8191 quarter samples
    range_nxt = ($signed(dw[31:16]) >= $signed(`MSID_MV_MIN)) &&
                ($signed(dw[31:16]) <= $signed(`MSID_MV_MAX)) &&
                ($signed(dw[15:0]) >= $signed(`MSID_MV_MIN)) &&
                ($signed(dw[15:0]) <= $signed(`MSID_MV_MAX));
    // Phases below the base and past the layout fall to default: no item
    if (idx[6:3] >= `MSID_PHASE_BASE) begin
      case (typ)
        `MSID_TYPE_INTEGER: begin
          case (rel)
            4'h0: begin
              hit_nxt = 1'b1;
              kind_nxt = `MSID_KIND_STEPS;
              index_nxt = {1'b0, d, 2'b00};
            end
            4'h1: begin
              hit_nxt = (d < `MSID_PATH2_DWORDS);
              kind_nxt = `MSID_KIND_STEPS;
              index_nxt = `MSID_PATH2_FIRST + {1'b0, d, 2'b00};
            end
            4'h2, 4'h4: begin
              dir_nxt = rel[2];
              hit_nxt = 1'b1;
              case (d)
                `MSID_REC_DISTP_A: begin
                  kind_nxt = `MSID_KIND_DISTP;
                  index_nxt = `MSID_SHAPE_16X8_0;
                end
                `MSID_REC_DISTP_B: begin
                  kind_nxt = `MSID_KIND_DISTP;
                  index_nxt = `MSID_SHAPE_8X16_0;
                end
                `MSID_REC_DIST8_A: begin
                  kind_nxt = `MSID_KIND_DIST8;
                  index_nxt = `MSID_SHAPE_8X8_0;
                end
                `MSID_REC_DIST8_B: begin
                  kind_nxt = `MSID_KIND_DIST8;
                  index_nxt = `MSID_SHAPE_8X8_2;
                end
                `MSID_REC_REF16: begin
                  kind_nxt = `MSID_KIND_REF16;
                  index_nxt = 6'h00;
                end
                `MSID_REC_MV16: begin
                  kind_nxt = `MSID_KIND_SHAPE_MV;
                  index_nxt = 6'h00;
                end
                `MSID_REC_REF8: begin
                  kind_nxt = `MSID_KIND_REF8;
                  index_nxt = `MSID_SHAPE_16X8_0;
                end
                default: begin
                  hit_nxt = 1'b0;
                end
              endcase
            end
            4'h3, 4'h5: begin
              hit_nxt = 1'b1;
              dir_nxt = (rel == 4'h5);
              kind_nxt = `MSID_KIND_SHAPE_MV;
              index_nxt = {3'b000, d} + 6'h01;
            end
            default: begin
              hit_nxt = 1'b0;
            end
          endcase
        end
        `MSID_TYPE_REFINE: begin
          hit_nxt = (rel < 4'h4);
          kind_nxt = `MSID_KIND_REFINE_MV;
          index_nxt = {2'b00, rel[1:0], d[2:1]};
          dir_nxt = d[0];
        end
        default: begin
          hit_nxt = 1'b0;
        end
      endcase
    end
    // Distortion masks and 16x16 record split
    case (kind_nxt)
      `MSID_KIND_DIST8: begin
        dist_lo_nxt = {2'b00, dw[`MSID_DIST8_BITS-1:0]};
        dist_hi_nxt = {2'b00, dw[16+`MSID_DIST8_BITS-1:16]};
      end
      `MSID_KIND_DISTP: begin
        dist_lo_nxt = {1'b0, dw[`MSID_DISTP_BITS-1:0]};
        dist_hi_nxt = {1'b0, dw[16+`MSID_DISTP_BITS-1:16]};
      end
      `MSID_KIND_REF16: begin
        ref_nxt = {28'h000_0000, dw[`MSID_REF16_MSB:`MSID_REF16_LSB]};
        dist_hi_nxt = 16'h0000;
      end
      default: begin
        dist_hi_nxt = dw[31:16];
      end
    endcase
  end

  // Registered item; fields of a non-item cycle hold their last values
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid_r <= 1'b0;
      out_req_type_r <= 2'h0;
      out_kind_r <= 3'h0;
      out_index_r <= 6'h00;
      out_dir_r <= 1'b0;
      out_step_v_r <= 16'h0000;
      out_step_h_r <= 16'h0000;
      out_ref_idx_r <= 32'h0000_0000;
      out_dist_lo_r <= 16'h0000;
      out_dist_hi_r <= 16'h0000;
      out_mv_y_r <= 16'h0000;
      out_mv_x_r <= 16'h0000;
      out_mv_in_range_r <= 1'b0;
    end else begin
      out_valid_r <= pop && hit_nxt;
      if (pop && hit_nxt) begin
        out_req_type_r <= typ;
        out_kind_r <= kind_nxt;
        out_index_r <= index_nxt;
        out_dir_r <= dir_nxt;
        out_step_v_r <= step_v_nxt;
        out_step_h_r <= step_h_nxt;
        out_ref_idx_r <= ref_nxt;
        out_dist_lo_r <= dist_lo_nxt;
        out_dist_hi_r <= dist_hi_nxt;
        out_mv_y_r <= dw[`MSID_MV_Y_MSB:`MSID_MV_Y_LSB];
        out_mv_x_r <= dw[`MSID_MV_X_MSB:`MSID_MV_X_LSB];
        out_mv_in_range_r <= range_nxt;
      end
    end
  end
endmodule // msid_decoder

// [test/msid_sender.sv]
`timescale 1ns/1ps
module msid_sender (
  input logic mclk, // Clock
  input logic msg_ready, // Buffer has room
  output logic msg_valid, // Dword offered
  output logic [31:0] msg_data, // Dword
  output logic msg_first, // Phase 0 dword 0
  output logic [1:0] msg_type // Request type
);
  // Idle bus at time zero
  initial begin
    msg_valid = 0;
    msg_data = 0;
    msg_first = 0;
    msg_type = 0;
  end
  // Offer one dword, hold it until taken; ready is stable between edges
  task push(input logic [31:0] d, input logic f, input logic [1:0] t);
    @(negedge mclk);
    msg_valid = 1;
    msg_data = d;
    msg_first = f;
    msg_type = t;
    while (msg_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
  endtask
  // Released data and type lines show the inverse, never a stale copy; valid and first go low
  task rel;
    @(negedge mclk);
    msg_valid = 0;
    msg_data = ~msg_data;
    msg_first = 0;
    msg_type = ~msg_type;
  endtask
endmodule // msid_sender

// [test/msid_monitor.sv]
`timescale 1ns/1ps
`include "msid_map.vh"
module msid_monitor (
  input logic mclk, // Clock
  input logic reset_n, // Async reset
  input logic dec_ready, // Consumer ready
  input logic out_valid, // Item pulse
  input logic [1:0] out_req_type, // Item type
  input logic [2:0] out_kind, // Item kind
  input logic [5:0] out_index, // Item number
  input logic [31:0] out_ref_idx, // Indices
  input logic [15:0] out_dist_lo, // Distortion
  input logic [15:0] out_dist_hi, // Distortion
  input logic [15:0] out_mv_y, // Vertical
  input logic [15:0] out_mv_x, // Horizontal
  input logic out_mv_in_range // Range flag
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Items only follow a pop, and a pop needs the consumer
  a_stall_no_item: assert property (!dec_ready |=> !out_valid)
    else $error("item while consumer stalled");
  a_type_known: assert property (out_valid |-> out_req_type <= 1)
    else $error("item for unknown type");
  a_refine_kind: assert property (out_valid && out_req_type == 1 |->
    out_kind == `MSID_KIND_REFINE_MV && out_index <= 15) else $error("bad refine item");
  a_step_index: assert property (out_valid && out_kind == `MSID_KIND_STEPS |->
    out_index[1:0] == 0 && out_index <= 52) else $error("bad step index");
  a_shape_index: assert property (out_valid && out_kind == `MSID_KIND_SHAPE_MV |->
    out_index <= 8) else $error("bad shape index");
  a_ref16_pack: assert property (out_valid && out_kind == `MSID_KIND_REF16 |->
    out_ref_idx[31:4] == 0 && out_dist_hi == 0) else $error("bad 16x16 fields");
  a_dist8_mask: assert property (out_valid && out_kind == `MSID_KIND_DIST8 |->
    out_dist_lo[15:14] == 0 && out_dist_hi[15:14] == 0) else $error("8x8 upper bits kept");
  a_distp_mask: assert property (out_valid && out_kind == `MSID_KIND_DISTP |->
    !out_dist_lo[15] && !out_dist_hi[15]) else $error("partition upper bit kept");
  a_range_flag: assert property (out_valid && out_kind == `MSID_KIND_REFINE_MV |->
    out_mv_in_range == (out_mv_y[15:13] inside {0, 7} && out_mv_x[15:13] inside {0, 7}))
    else $error("range flag wrong");
endmodule // msid_monitor
bind msid_decoder msid_monitor u_mon (.mclk, .reset_n, .dec_ready, .out_valid, .out_req_type,
  .out_kind, .out_index, .out_ref_idx, .out_dist_lo, .out_dist_hi, .out_mv_y, .out_mv_x,
  .out_mv_in_range);

// [test/msid_tb.sv]
`timescale 1ns/1ps
`include "msid_map.vh"
module testbench;
  logic mclk = 0;
  logic reset_n = 0;
  logic dec_ready = 0;
  logic busy = 0;
  wire msg_valid, msg_first, msg_ready, out_valid, out_dir, out_mv_in_range;
  wire [31:0] msg_data, out_ref_idx;
  wire [1:0] msg_type, out_req_type;
  wire [2:0] out_kind;
  wire [5:0] out_index;
  wire [15:0] out_step_v, out_step_h, out_dist_lo, out_dist_hi, out_mv_y, out_mv_x;
  int err_total = 0;
  int n_compared = 0;
  logic [43:0] expq[$];
  // Edge values of the vector range, one per 8x8 group and direction
  logic [31:0] vt[8] = '{32'he000_1fff, 32'h1fff_e000, 32'hdfff_0000, 32'h0000_2000,
    32'hffff_0004, 32'h8000_7fff, 32'h0001_fffc, 32'h2000_dfff};
  always #5 mclk = ~mclk;
  msid_sender u_snd (.mclk, .msg_ready, .msg_valid, .msg_data, .msg_first, .msg_type);
  msid_decoder DUT (.mclk, .reset_n, .msg_valid, .msg_ready, .msg_data, .msg_first, .msg_type,
    .dec_ready, .out_valid, .out_req_type, .out_kind, .out_index, .out_dir, .out_step_v,
    .out_step_h, .out_ref_idx, .out_dist_lo, .out_dist_hi, .out_mv_y, .out_mv_x,
    .out_mv_in_range);
  task cmp(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // Sign bits 15:13 all equal means within -8192..8191
  function logic inr(input logic [31:0] d);
    return (&d[31:29] | ~|d[31:29]) & (&d[15:13] | ~|d[15:13]);
  endfunction
  // Expected {kind, index, dir} of absolute dword i, top bit marks an item
  function logic [10:0] exp_item(input logic [1:0] t, input int i);
    int p, d;
    logic r;
    p = i / 8 - 3;
    d = i % 8;
    r = p > 3;
    if (p < 0 || t > 1) return 0;
    if (t == 1) return p < 4 ? {1'b1, `MSID_KIND_REFINE_MV, 6'(4 * p + d / 2), 1'(d)} : 0;
    if (p == 0) return {1'b1, `MSID_KIND_STEPS, 6'(4 * d), 1'b0};
    if (p == 1) return d < 6 ? {1'b1, `MSID_KIND_STEPS, 6'(32 + 4 * d), 1'b0} : 0;
    if (p > 5) return 0;
    if (p % 2 == 1) return {1'b1, `MSID_KIND_SHAPE_MV, 6'(d + 1), r};
    case (d)
      0: return {1'b1, `MSID_KIND_DISTP, 6'd1, r};
      1: return {1'b1, `MSID_KIND_DISTP, 6'd3, r};
      2: return {1'b1, `MSID_KIND_DIST8, 6'd5, r};
      3: return {1'b1, `MSID_KIND_DIST8, 6'd7, r};
      4: return {1'b1, `MSID_KIND_REF16, 6'd0, r};
      5: return {1'b1, `MSID_KIND_SHAPE_MV, 6'd0, r};
      6: return {1'b1, `MSID_KIND_REF8, 6'd1, r};
      default: return 0;
    endcase
  endfunction
  task send_msg(input logic [1:0] t, input int n);
    logic [31:0] d;
    logic [10:0] e;
    busy = 1;
    for (int i = 0; i < n; i++) begin
      d = (t == 1 && i > 23) ? vt[(i / 8 - 3) * 2 + i % 2] : 32'h9e37_79b9 * (i + 1);
      e = exp_item(t, i);
      if (e[10]) expq.push_back({t, e[9:0], d});
      u_snd.push(d, i == 0, t);
    end
    u_snd.rel();
    busy = 0;
  endtask
  // Check each item against the oldest expectation
  task chk;
    logic [43:0] e;
    logic [15:0] v, h;
    if (expq.size() == 0) begin
      cmp(out_valid, 0);
      return;
    end
    e = expq.pop_front();
    for (int k = 0; k < 4; k++) begin
      v[4*k+:4] = e[8*k+4+:4];
      h[4*k+:4] = e[8*k+:4];
    end
    cmp(out_req_type, e[43:42]);
    cmp(out_kind, e[41:39]);
    cmp(out_index, e[38:33]);
    cmp(out_dir, e[32]);
    case (e[41:39])
      `MSID_KIND_STEPS: cmp({out_step_v, out_step_h}, {v, h});
      `MSID_KIND_REF8: cmp(out_ref_idx, e[31:0]);
      `MSID_KIND_REF16: begin
        cmp(out_ref_idx, e[19:16]);
        cmp(out_dist_lo, e[15:0]);
      end
      `MSID_KIND_DIST8: cmp({out_dist_hi, out_dist_lo}, e[31:0] & 32'h3fff_3fff);
      `MSID_KIND_DISTP: cmp({out_dist_hi, out_dist_lo}, e[31:0] & 32'h7fff_7fff);
      default: cmp({out_mv_y, out_mv_x}, e[31:0]);
    endcase
    if (e[43:42] == 1) cmp(out_mv_in_range, inr(e[31:0]));
  endtask
  // Pulse lasts one cycle, so the falling edge sees it exactly once
  always @(negedge mclk) if (out_valid === 1'b1) chk();
  task drain(input string nm);
    for (int n = 0; n < 400 && (busy || expq.size() > 0); n++) @(negedge mclk);
    repeat (2) @(negedge mclk);
    cmp(expq.size(), 0);
    cmp(msg_ready, 1);
    $display("test %s done", nm);
  endtask
  task end_sim;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Whole run is well under 1000 cycles
  initial begin
    #20000;
    err_total++;
    end_sim();
  end
  // Tests: stalled fill, unknown type, reset mid-run, refinement
  initial begin
    repeat (6) @(negedge mclk);
    cmp(msg_ready, 1);
    reset_n = 1;
    fork
      send_msg(0, 80);
    join_none
    for (int n = 0; n < 100 && msg_ready !== 1'b0; n++) @(negedge mclk);
    cmp(msg_ready, 0);
    repeat (4) @(negedge mclk);
    dec_ready = 1;
    drain("integer search");
    send_msg(2, 32);
    drain("unknown type");
    dec_ready = 0;
    send_msg(0, 20);
    @(negedge mclk);
    reset_n = 0;
    expq.delete();
    @(negedge mclk);
    cmp(msg_ready, 1);
    reset_n = 1;
    dec_ready = 1;
    send_msg(1, 56);
    drain("refine after reset");
    end_sim();
  end
endmodule // testbench
